// ### slcirq_monitor.sv
// Purpose: Port checker for slcirq_top.
// Assumes: One clock domain, RST asynchronous and active high.
// Notes:   Shadow flops track the select, busy state and mask writes.
module slcirq_monitor
    import slcirq_pkg::*;
(
    input wire logic              MCLK,
    input wire logic              RST,
    input wire logic              CE,
    input wire logic [15:0]       ADDR,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [7:0]        WDATA,
    input wire logic [7:0]        RDATA,
    input wire logic [63:0]       SOCKET_FLAGS,
    input wire slcirq_result_type CMD_RESULT,
    input wire logic              CMD_DONE,
    input wire logic              TX_ACK,
    input wire logic              TX_REQ,
    input wire logic [6:0]        TX_KIND,
    input wire logic [127:0]      LINK_LOCAL_ADDR,
    input wire logic [127:0]      GLOBAL_ADDR,
    input wire logic [127:0]      SOURCE_V6_ADDR,
    input wire logic              INT_REQ
);
    logic [7:0] sel_q;
    logic       busy_q;
    logic       mwr_q;
    wire        wr_ok = CE && WR;
    wire        idle  = !TX_REQ && !busy_q;

    function automatic logic [7:0] summ(logic [63:0] f);
        for (int i = 0; i < 8; i++)
            summ[i] = |f[8*i +: 8];
    endfunction

    always_ff @(posedge MCLK or posedge RST)
        if (RST)
            sel_q <= 8'h00;
        else if (wr_ok && ADDR == OFS_SRC_SELECT)
            sel_q <= WDATA;

    always_ff @(posedge MCLK or posedge RST)
        if (RST)
            busy_q <= 1'b0;
        else if (CE && TX_REQ && TX_ACK)
            busy_q <= 1'b1;
        else if (CE && CMD_DONE)
            busy_q <= 1'b0;

    // Until any mask is written every enable is still zero.
    always_ff @(posedge MCLK or posedge RST)
        if (RST)
            mwr_q <= 1'b0;
        else if (wr_ok && (ADDR == OFS_SOCK_MASK || ADDR == OFS_SL_MASK
                 || ADDR == OFS_COMMON_MASK))
            mwr_q <= 1'b1;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    sequence s_done_read;
        CE && busy_q && CMD_DONE ##1 CE && RD && ADDR == OFS_SL_COMMAND;
    endsequence
    sequence s_cmd_timeout_flag_read;
        CE && busy_q && CMD_DONE && CMD_RESULT.timeout
        ##2 CE && RD && ADDR == OFS_SL_FLAGS;
    endsequence

    chk_cmd_issue: assert property (
        idle && wr_ok && ADDR == OFS_SL_COMMAND && WDATA[6:0] != 7'h00
        |=> TX_REQ && {1'b0, TX_KIND} == ($past(WDATA) & CMD_VALID_BITS))
        else $error("command not issued");
    chk_req_hold: assert property (
        TX_REQ && !TX_ACK |=> TX_REQ && $stable(TX_KIND))
        else $error("request dropped early");
    chk_req_drop: assert property (
        CE && TX_REQ && TX_ACK |=> !TX_REQ) else $error("request stuck");
    chk_cmd_self_clear: assert property (
        s_done_read |=> RDATA == 8'h00) else $error("command not cleared");
    chk_cmd_timeout_flag_flag: assert property (
        s_cmd_timeout_flag_read |=> RDATA[7]) else $error("timeout flag missing");
    chk_clear_reads_zero: assert property (
        CE && RD && (ADDR == OFS_COMMON_CLEAR || ADDR == OFS_SL_CLEAR)
        |=> RDATA == 8'h00) else $error("clear register readable");
    chk_summary_bits: assert property (
        CE && RD && ADDR == OFS_SOCK_SUMMARY && $stable(SOCKET_FLAGS)
        |=> RDATA == summ($past(SOCKET_FLAGS))) else $error("bad summary");
    chk_no_int_unmasked: assert property (
        !mwr_q |-> !INT_REQ) else $error("interrupt with all masks zero");
    chk_src_fixed: assert property (
        CE && $past(CE) && sel_q == $past(sel_q) && $stable(GLOBAL_ADDR)
        && (sel_q == SRC_LLA || sel_q == SRC_GUA) && $stable(LINK_LOCAL_ADDR)
        |-> SOURCE_V6_ADDR == (sel_q == SRC_LLA ? LINK_LOCAL_ADDR
                                                : GLOBAL_ADDR))
        else $error("fixed source wrong");
endmodule

bind slcirq_top slcirq_monitor i_slcirq_monitor (.*);

// ### slcirq_pkg.sv
// Purpose: Constants and types for the socket-less command and irq masking.
// Assumes: 16-bit byte-wide register port, 8-bit data.
// Notes:   Offsets are byte addresses of the register map.
package slcirq_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] OFS_COMMON_FLAGS  = 16'h2100;
    localparam logic [15:0] OFS_SOCK_SUMMARY  = 16'h2101;
    localparam logic [15:0] OFS_SL_FLAGS      = 16'h2102;
    localparam logic [15:0] OFS_COMMON_MASK   = 16'h2104;
    localparam logic [15:0] OFS_COMMON_CLEAR  = 16'h2108;
    localparam logic [15:0] OFS_SOCK_MASK     = 16'h2114;
    localparam logic [15:0] OFS_SL_MASK       = 16'h2124;
    localparam logic [15:0] OFS_SL_CLEAR      = 16'h2128;
    localparam logic [15:0] OFS_SRC_SELECT    = 16'h212c;
    localparam logic [15:0] OFS_SL_COMMAND    = 16'h2130;

    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] COMMON_VALID_BITS = 8'h97;
    localparam logic [7:0] CMD_VALID_BITS    = 8'h7f;
    localparam logic [7:0] REG_RESET         = 8'h00;
    localparam int         SL_TIMEOUT_BIT    = 7;
    localparam int         NUM_SOCKETS       = 8;

    localparam logic [7:0] SRC_AUTO          = 8'h00;
    localparam logic [7:0] SRC_LLA           = 8'h02;
    localparam logic [7:0] SRC_GUA           = 8'h03;

    // Link-local unicast prefix fe80::/10.
    localparam logic [9:0] LLA_PREFIX        = 10'h3fa;

    typedef enum logic [1:0] {
        SLC_IDLE = 2'b00,
        SLC_SEND = 2'b01,
        SLC_WAIT = 2'b10
    } slcirq_state_type;

    typedef struct packed {
        logic [7:0] reply;
        logic       timeout;
    } slcirq_result_type;

endpackage

// ### slcirq_top.sv
// Purpose: Interrupt clear/mask registers and socket-less command unit.
// Assumes: Protocol engine supplies event pulses and a done handshake.
// Notes:   One byte register port; reads return data on the next edge.
//
// Functional notes
// - Writing one to common clear bits 7,4,2,1,0 clears that common flag.
// - Socket mask holds eight enables gating each socket summary bit.
// - Socket-less mask holds one enable per socket-less flag.
// - Writing one to any socket-less clear bit clears that flag.
// - Automatic source select picks link-local or global by destination.
// - Select 0x02 forces link-local source, 0x03 forces global source.
// - Writing one to a command bit transmits the matching packet.
// - Command bit clears itself when the operation finishes.
// - Command outcome reported only through socket-less flags.
// - Masks, source select and command read zero after reset.
// - Timeout flag on no reply; per-command flag on reply arrival.
// - Socket summary bit is one while that socket's flags are nonzero.
module slcirq_top
    import slcirq_pkg::*;
(
    input  wire logic                  MCLK,
    input  wire logic                  RST,
    input  wire logic                  CE,
    input  wire logic [15:0]           ADDR,
    input  wire logic                  WR,
    input  wire logic                  RD,
    input  wire logic [7:0]            WDATA,
    output logic      [7:0]            RDATA,
    input  wire logic [7:0]            COMMON_EVENT,
    input  wire logic [63:0]           SOCKET_FLAGS,
    input  wire logic                  RA_RECEIVED,
    input  wire slcirq_result_type     CMD_RESULT,
    input  wire logic                  CMD_DONE,
    input  wire logic                  TX_ACK,
    output logic                       TX_REQ,
    output logic      [6:0]            TX_KIND,
    input  wire logic [127:0]          DEST_V6_ADDR,
    input  wire logic [127:0]          LINK_LOCAL_ADDR,
    input  wire logic [127:0]          GLOBAL_ADDR,
    output logic      [127:0]          SOURCE_V6_ADDR,
    output logic                       INT_REQ
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]        common_flags_q;
    logic [7:0]        common_mask_q;
    logic [7:0]        sock_mask_q;
    logic [7:0]        sl_flags_q;
    logic [7:0]        sl_mask_q;
    logic [7:0]        src_sel_q;
    logic [7:0]        cmd_q;
    logic [7:0]        sock_summary;
    logic [7:0]        sl_set;
    logic              cmd_accept;
    slcirq_state_type  state_q;

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Socket summary
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_SOCKETS; g++)
        begin : g_sum
            assign sock_summary[g] = |SOCKET_FLAGS[g*8 +: 8];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Common flags
    // ------------------------------------------------------------------
    // A set in the same cycle as a clear wins so no event is lost.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            common_flags_q <= REG_RESET;
        else if (CE)
        begin
            if (WR && hit(ADDR, OFS_COMMON_CLEAR))
                common_flags_q <= ((common_flags_q
                                  & ~(WDATA & COMMON_VALID_BITS))
                                  | COMMON_EVENT) & COMMON_VALID_BITS;
            else
                common_flags_q <= (common_flags_q | COMMON_EVENT)
                                  & COMMON_VALID_BITS;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            common_mask_q <= REG_RESET;
        else if (CE && WR && hit(ADDR, OFS_COMMON_MASK))
            common_mask_q <= WDATA & COMMON_VALID_BITS;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            sock_mask_q <= REG_RESET;
        else if (CE && WR && hit(ADDR, OFS_SOCK_MASK))
            sock_mask_q <= WDATA;
    end

    // ------------------------------------------------------------------
    // Socket-less flags and mask
    // ------------------------------------------------------------------
    // Result is only taken while a command waits, so stray results from
    // the engine cannot forge a completion.
    always_comb
    begin
        sl_set = {7'h00, RA_RECEIVED};
        if (state_q == SLC_WAIT && CMD_DONE)
        begin
            if (CMD_RESULT.timeout)
                sl_set[SL_TIMEOUT_BIT] = 1'b1;
            else
                sl_set = sl_set | (CMD_RESULT.reply & cmd_q
                                   & CMD_VALID_BITS);
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            sl_flags_q <= REG_RESET;
        else if (CE)
        begin
            if (WR && hit(ADDR, OFS_SL_CLEAR))
                sl_flags_q <= (sl_flags_q & ~WDATA) | sl_set;
            else
                sl_flags_q <= sl_flags_q | sl_set;
        end
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            sl_mask_q <= REG_RESET;
        else if (CE && WR && hit(ADDR, OFS_SL_MASK))
            sl_mask_q <= WDATA;
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            src_sel_q <= REG_RESET;
        else if (CE && WR && hit(ADDR, OFS_SRC_SELECT))
            src_sel_q <= WDATA;
    end

    // ------------------------------------------------------------------
    // Command unit
    // ------------------------------------------------------------------
    // A write while busy is dropped, not queued.
    assign cmd_accept = WR && hit(ADDR, OFS_SL_COMMAND)
                        && (state_q == SLC_IDLE)
                        && ((WDATA & CMD_VALID_BITS) != REG_RESET);

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_q <= SLC_IDLE;
            cmd_q   <= REG_RESET;
        end
        else if (CE)
        begin
            case (state_q)
                SLC_IDLE:
                begin
                    if (cmd_accept)
                    begin
                        cmd_q   <= WDATA & CMD_VALID_BITS;
                        state_q <= SLC_SEND;
                    end
                end
                SLC_SEND:
                begin
                    if (TX_ACK)
                        state_q <= SLC_WAIT;
                end
                SLC_WAIT:
                begin
                    if (CMD_DONE)
                    begin
                        cmd_q   <= REG_RESET;
                        state_q <= SLC_IDLE;
                    end
                end
                default:
                begin
                    cmd_q   <= REG_RESET;
                    state_q <= SLC_IDLE;
                end
            endcase
        end
    end

    assign TX_REQ  = (state_q == SLC_SEND);
    assign TX_KIND = cmd_q[6:0];

    // ------------------------------------------------------------------
    // IPv6 source selection
    // ------------------------------------------------------------------
    // Reserved select values fall back to automatic choice.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            SOURCE_V6_ADDR <= '0;
        else if (CE)
        begin
            case (src_sel_q)
                SRC_LLA: SOURCE_V6_ADDR <= LINK_LOCAL_ADDR;
                SRC_GUA: SOURCE_V6_ADDR <= GLOBAL_ADDR;
                default:
                begin
                    if (DEST_V6_ADDR[127:118] == LLA_PREFIX)
                        SOURCE_V6_ADDR <= LINK_LOCAL_ADDR;
                    else
                        SOURCE_V6_ADDR <= GLOBAL_ADDR;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output and read port
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            INT_REQ <= 1'b0;
        else if (CE)
            INT_REQ <= |(common_flags_q & common_mask_q)
                       | |(sock_summary & sock_mask_q)
                       | |(sl_flags_q & sl_mask_q);
    end

    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            RDATA <= REG_RESET;
        else if (CE && RD)
        begin
            case (ADDR)
                OFS_COMMON_FLAGS: RDATA <= common_flags_q;
                OFS_SOCK_SUMMARY: RDATA <= sock_summary;
                OFS_SL_FLAGS:     RDATA <= sl_flags_q;
                OFS_COMMON_MASK:  RDATA <= common_mask_q;
                OFS_SOCK_MASK:    RDATA <= sock_mask_q;
                OFS_SL_MASK:      RDATA <= sl_mask_q;
                OFS_SRC_SELECT:   RDATA <= src_sel_q;
                OFS_SL_COMMAND:   RDATA <= cmd_q;
                default:          RDATA <= REG_RESET;
            endcase
        end
    end

endmodule

// ### tb_slcirq_top.sv
// Purpose: Self-checking bench for slcirq_top.
// Assumes: Inputs change on the falling edge of MCLK.
// Notes:   The engine side is driven by hand; CE stays high except during one dropped socket mask write.
module tb_slcirq_top import slcirq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 0, RST = 1, CE = 1, WR = 0, RD = 0, RA_RECEIVED = 0;
    logic CMD_DONE = 0, TX_ACK = 0, TX_REQ, INT_REQ;
    logic [15:0] ADDR = '0;
    logic [7:0] WDATA = '0, COMMON_EVENT = '0, RDATA;
    logic [6:0] TX_KIND;
    logic [63:0] SOCKET_FLAGS = '0;
    slcirq_result_type CMD_RESULT = '0;
    logic [127:0] LINK_LOCAL_ADDR = {LLA_PREFIX, 118'h1};
    logic [127:0] GLOBAL_ADDR = {16'h2001, 112'h1};
    logic [127:0] DEST_V6_ADDR = '0, SOURCE_V6_ADDR;
    int errors = 0, n_checks = 0;
    logic [15:0] zr [4] = '{OFS_SOCK_MASK, OFS_SL_MASK, OFS_SRC_SELECT,
                            OFS_SL_COMMAND};
    logic [31:0] rows [7] = '{{OFS_SOCK_MASK, 8'h3c, 8'h3c},
        {OFS_COMMON_MASK, 8'hff, 8'h97},
        {OFS_SL_MASK, 8'ha5, 8'ha5}, {OFS_SRC_SELECT, 8'h02, 8'h02},
        {OFS_COMMON_CLEAR, 8'hff, 8'h00}, {OFS_SL_CLEAR, 8'hff, 8'h00},
        {16'h2200, 8'h5a, 8'h00}};

    slcirq_top i_slcirq_top (.*);

    initial forever #4 MCLK = ~MCLK;

    task automatic results();
        $display("errors=%0d n_checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk128(input logic [127:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        ADDR = a;
        WDATA = d;
        WR = 1'b1;
        @(negedge MCLK) WR = 1'b0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        ADDR = a;
        RD = 1'b1;
        @(negedge MCLK) RD = 1'b0;
        chk8(RDATA, e);
    endtask

    task automatic cmd(input logic [7:0] b, r, e, input logic t);
        wr(OFS_SL_COMMAND, b);
        // One stalled cycle proves the request waits for the engine.
        @(negedge MCLK);
        chk8({1'b0, TX_KIND}, b & CMD_VALID_BITS);
        TX_ACK = 1'b1;
        @(negedge MCLK) TX_ACK = 1'b0;
        wr(OFS_SL_COMMAND, b ^ 8'h7f);
        rdc(OFS_SL_COMMAND, b & CMD_VALID_BITS);
        CMD_RESULT = {r, t};
        CMD_DONE = 1'b1;
        @(negedge MCLK) CMD_DONE = 1'b0;
        rdc(OFS_SL_COMMAND, 8'h00);
        rdc(OFS_SL_FLAGS, e);
        chk8({7'h00, INT_REQ}, 8'h01);
        wr(OFS_SL_CLEAR, e);
        rdc(OFS_SL_FLAGS, 8'h00);
        chk8({7'h00, INT_REQ}, 8'h00);
    endtask

    initial
    begin
        #20000;
        errors++;
        results();
    end

    initial
    begin
        repeat (16) @(negedge MCLK);
        RST = 1'b0;
        foreach (zr[i])
            rdc(zr[i], 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i][31:16], rows[i][15:8]);
            rdc(rows[i][31:16], rows[i][7:0]);
        end
        wr(OFS_SL_MASK, 8'hff);
        for (int i = 0; i < 7; i++)
            cmd(8'h01 << i, 8'h01 << i, 8'h01 << i, 1'b0);
        cmd(8'h84, 8'h00, 8'h80, 1'b1);
        RA_RECEIVED = 1'b1;
        @(negedge MCLK) RA_RECEIVED = 1'b0;
        rdc(OFS_SL_FLAGS, 8'h01);
        wr(OFS_SL_CLEAR, 8'h01);
        rdc(OFS_SL_FLAGS, 8'h00);
        COMMON_EVENT = 8'hff;
        @(negedge MCLK) COMMON_EVENT = 8'h00;
        rdc(OFS_COMMON_FLAGS, 8'h97);
        wr(OFS_COMMON_CLEAR, 8'h10);
        rdc(OFS_COMMON_FLAGS, 8'h87);
        chk8({7'h00, INT_REQ}, 8'h01);
        // An event in the same cycle as its clear must not be lost.
        COMMON_EVENT = 8'h01;
        wr(OFS_COMMON_CLEAR, 8'h01);
        COMMON_EVENT = 8'h00;
        rdc(OFS_COMMON_FLAGS, 8'h87);
        wr(OFS_COMMON_CLEAR, 8'hff);
        rdc(OFS_COMMON_FLAGS, 8'h00);
        chk8({7'h00, INT_REQ}, 8'h00);
        SOCKET_FLAGS = 64'h0000_4000_0000_0001;
        @(negedge MCLK);
        rdc(OFS_SOCK_SUMMARY, 8'h21);
        chk8({7'h00, INT_REQ}, 8'h01);
        wr(OFS_SOCK_MASK, 8'h1c);
        @(negedge MCLK);
        chk8({7'h00, INT_REQ}, 8'h00);
        // A write while the clock enable is low must leave state alone.
        CE = 1'b0;
        wr(OFS_SOCK_MASK, 8'hff);
        CE = 1'b1;
        rdc(OFS_SOCK_MASK, 8'h1c);
        chk128(SOURCE_V6_ADDR, LINK_LOCAL_ADDR);
        wr(OFS_SRC_SELECT, 8'h03);
        @(negedge MCLK);
        chk128(SOURCE_V6_ADDR, GLOBAL_ADDR);
        wr(OFS_SRC_SELECT, SRC_AUTO);
        DEST_V6_ADDR = {LLA_PREFIX, 118'h5};
        @(negedge MCLK);
        chk128(SOURCE_V6_ADDR, LINK_LOCAL_ADDR);
        DEST_V6_ADDR = {16'h2001, 112'h5};
        @(negedge MCLK);
        chk128(SOURCE_V6_ADDR, GLOBAL_ADDR);
        // A second reset in mid-run must bring both masks in zr, source select and command back to zero.
        RST = 1'b1;
        @(negedge MCLK);
        RST = 1'b0;
        foreach (zr[i])
            rdc(zr[i], 8'h00);
        chk8({7'h00, INT_REQ}, 8'h00);
        results();
    end
endmodule
